// *** ads_pkg.sv ***
// Package with constants and types for the accessory detect and switch control block
package ads_pkg;

  // Register offsets (word addresses on the plain register port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_DEVTYPE = 4'h1;
  localparam logic [3:0] REG_INTSTAT = 4'h2;
  localparam logic [3:0] REG_SWITCH = 4'h3;
  localparam logic [3:0] REG_IDSTAT = 4'h4;

  // Control register field positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_MANUAL_SEL_BIT = 1;
  localparam int CTRL_SWITCH_HOLD_OVERRIDE_BIT = 2;
  localparam int CTRL_WAIT_BIT = 3;
  localparam int CTRL_TTY_SPKL_BIT = 4;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h02;

  // Interrupt status field positions
  localparam int INT_ATTACH_BIT = 0;
  localparam int INT_DETACH_BIT = 1;
  localparam int INT_UNKNOWN_BIT = 2;

  // Device type field positions
  localparam int DT_USB_BIT = 0;
  localparam int DT_UART_BIT = 1;
  localparam int DT_USB_CHG_BIT = 2;
  localparam int DT_DED_CHG_BIT = 3;
  localparam int DT_5W_BIT = 4;
  localparam int DT_AV_BIT = 5;
  localparam int DT_TTY_BIT = 6;
  localparam int DT_AUDIO1_BIT = 7;
  localparam int DT_JIG_BIT = 8;
  localparam int DT_FACTORY_BIT = 9;

  // Switch vector positions
  localparam int SW_DP_DM = 0;
  localparam int SW_RXD_TXD = 1;
  localparam int SW_SPKR_DP = 2;
  localparam int SW_SPKL_DM = 3;
  localparam int SW_MIC_VBUS = 4;
  localparam int SW_OTG_VBUS = 5;
  localparam int SW_VBUS_PATH = 6;

  // ADC codes
  localparam logic [4:0] ADC_RESERVED0 = 5'h00;
  localparam logic [4:0] ADC_S0 = 5'h01;
  localparam logic [4:0] ADC_S12 = 5'h0D;
  localparam logic [4:0] ADC_UART_JIG2 = 5'h0E;
  localparam logic [4:0] ADC_UART_JIG1 = 5'h0F;
  localparam logic [4:0] ADC_USB_JIG2 = 5'h10;
  localparam logic [4:0] ADC_USB_JIG1 = 5'h11;
  localparam logic [4:0] ADC_FACTORY = 5'h12;
  localparam logic [4:0] ADC_AUDIO2 = 5'h13;
  localparam logic [4:0] ADC_PERIPH = 5'h14;
  localparam logic [4:0] ADC_RESERVED21 = 5'h15;
  localparam logic [4:0] ADC_UART = 5'h16;
  localparam logic [4:0] ADC_5W_T1 = 5'h17;
  localparam logic [4:0] ADC_RESERVED24 = 5'h18;
  localparam logic [4:0] ADC_RESERVED25 = 5'h19;
  localparam logic [4:0] ADC_AV = 5'h1A;
  localparam logic [4:0] ADC_5W_T2 = 5'h1B;
  localparam logic [4:0] ADC_RESERVED28 = 5'h1C;
  localparam logic [4:0] ADC_TTY = 5'h1D;
  localparam logic [4:0] ADC_AUDIO1 = 5'h1E;
  localparam logic [4:0] ADC_ID_LINE_FLOATING = 5'h1F;

  // Switch close wait time in detection clock cycles
  localparam logic [15:0] WAIT_CYCLES = 16'h0400;

  // Accessory classes
  typedef enum logic [3:0] {
    ACC_NONE, ACC_USB_HOST, ACC_UART, ACC_USB_CHG, ACC_DED_CHG, ACC_5W,
    ACC_AV, ACC_TTY, ACC_AUDIO1, ACC_USB_JIG, ACC_UART_JIG, ACC_FACTORY,
    ACC_BUTTON, ACC_UNKNOWN
  } ads_acc_e;

  // Detection states, Gray along standby, identify, active
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_IDENT = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_UNKNOWN = 2'b10
  } ads_state_e;

endpackage

// *** ads_id_if.sv ***
// Interface carrying synchronised ID and VBUS sense between the top and the classifier
`timescale 1ns/1ps
`default_nettype none
interface ads_id_if;
  logic [4:0] adc_code;
  logic id_open;
  logic id_not_gnd;
  logic id_high_v;
  logic vbus_present;
  ads_pkg::ads_acc_e acc;
  modport top (output adc_code, id_open, id_not_gnd, id_high_v, vbus_present, input acc);
  modport cls (input adc_code, id_open, id_not_gnd, id_high_v, vbus_present, output acc);
endinterface
`default_nettype wire

// *** ads_classify.sv ***
// Accessory classifier from ID comparators, ADC code and VBUS sense
`timescale 1ns/1ps
`default_nettype none
module ads_classify (
  ads_id_if.cls id
);

  // Map the ADC code to an accessory class
  function automatic ads_pkg::ads_acc_e decode_adc(input logic [4:0] code);
    ads_pkg::ads_acc_e r;
    r = ads_pkg::ACC_UNKNOWN;
    if (code >= ads_pkg::ADC_S0 && code <= ads_pkg::ADC_S12) begin
      r = ads_pkg::ACC_BUTTON; // RQ19
    end else begin
      case (code)
        ads_pkg::ADC_UART_JIG2, ads_pkg::ADC_UART_JIG1: r = ads_pkg::ACC_UART_JIG; // RQ19
        ads_pkg::ADC_USB_JIG2, ads_pkg::ADC_USB_JIG1: r = ads_pkg::ACC_USB_JIG; // RQ19
        ads_pkg::ADC_FACTORY: r = ads_pkg::ACC_FACTORY; // RQ19
        ads_pkg::ADC_UART: r = ads_pkg::ACC_UART; // RQ20
        ads_pkg::ADC_5W_T1, ads_pkg::ADC_5W_T2: r = ads_pkg::ACC_5W; // RQ20
        ads_pkg::ADC_AV: r = ads_pkg::ACC_AV; // RQ20
        ads_pkg::ADC_TTY: r = ads_pkg::ACC_TTY; // RQ20
        ads_pkg::ADC_AUDIO1: r = ads_pkg::ACC_AUDIO1; // RQ20
        // Audio type 2 and peripheral have no switch set, so unknown
        default: r = ads_pkg::ACC_UNKNOWN; // RQ21
      endcase
    end
    return r;
  endfunction

  // Comparator pattern first, then the ADC code
  always_comb begin
    if (id.id_open && id.id_not_gnd && id.id_high_v) begin
      id.acc = ads_pkg::ACC_FACTORY; // RQ18
    end else if (id.id_open && id.id_not_gnd) begin
      // Floating ID: host with VBUS, else nothing attached
      id.acc = id.vbus_present ? ads_pkg::ACC_USB_HOST : ads_pkg::ACC_NONE; // RQ18
    end else if (!id.id_open && id.id_not_gnd) begin
      id.acc = decode_adc(id.adc_code); // RQ18
    end else begin
      id.acc = ads_pkg::ACC_UNKNOWN; // RQ18
    end
  end

endmodule
`default_nettype wire

// *** ads_top.sv ***
// Accessory detect and signal switch control, top level with register port
// Overview of operation
// RQ1: TTY identified sets TTY type bit and attach flag.
// RQ2: TTY closes right audio and mic; left only with left speaker enable.
// RQ3: TTY keeps OTG and VBUS path switches open.
// RQ4: TTY has no key detection; detach as audio type 1.
// RQ5: UART cable closes RxD and TxD switches.
// RQ6: UART: Id_line_floating rising sets detach, returns to standby.
// RQ7: Host on floating ID sets USB bit, routes data lines.
// RQ8: Hold closes at once; wait set: after wait time; else until written.
// RQ9: Host raises data only after data switches close.
// RQ10: USB host: VBUS sense falling sets detach, enters standby.
// RQ11: Charger sets its type bit; data closed for USB charger only.
// RQ12: Any charger: VBUS sense falling sets detach, enters standby.
// RQ13: 5-wire or A/V charger sets matching type bit.
// RQ14: Automatic identification runs while manual select is one.
// RQ15: Unknown accessory sets only unknown attach flag.
// RQ16: Unknown: VBUS falling or Id_line_floating rising sets detach, standby.
// RQ17: Reset bit write acts as hardware reset; the sense pipeline and read data here reset on RST_I only.
// RQ18: Comparator pattern decodes resistor, ground, floating, factory.
// RQ19: ADC codes map buttons, UART jigs, USB jigs, factory.
// RQ20: ADC codes map audio, peripheral, UART, 5W, A/V, TTY, float; here audio type 2 and peripheral decode as unknown.
// RQ21: Reserved ADC codes map to no known accessory.
// RQ22: Standby holds every routing switch open.
// RQ23: Wait time is a configurable cycle count.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ads_top #(
  parameter logic [15:0] WAIT_COUNT = ads_pkg::WAIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // Analog sense inputs
  input wire logic ID_OPEN_COMPARATOR_I,
  input wire logic ID_NOT_GROUNDED_COMPARATOR_I,
  input wire logic ID_HIGH_VOLTAGE_COMPARATOR_I,
  input wire logic VBUS_PRESENT_SENSE_I,
  input wire logic [4:0] ID_ADC_CODE_I,
  // Switch controls
  output logic SW_HOST_DATA_O,
  output logic SW_UART_O,
  output logic SW_RIGHT_AUDIO_O,
  output logic SW_LEFT_AUDIO_O,
  output logic SW_MIC_VBUS_O,
  output logic OTG_VBUS_SWITCH_O,
  output logic VBUS_PATH_SWITCH_O,
  output logic KEY_DETECT_EN_O
);

  ads_id_if id_bus();

  ads_pkg::ads_state_e state_r;
  ads_pkg::ads_acc_e acc_r;

  logic [7:0] ctrl_r;
  logic [9:0] devtype_r;
  logic [2:0] intstat_r;

  logic [6:0] sw_r;
  logic [6:0] sw_nxt;

  logic [15:0] wait_cnt_r;
  logic data_ok_r;

  logic soft_rst;
  logic rst_all;

  logic [2:0] s_open_r, s_ngnd_r, s_hv_r, s_vbus_r;
  logic open_q, ngnd_q, hv_q, vbus_q;
  logic open_prev_r, vbus_prev_r;
  logic [4:0] adc_r;
  logic open_rise, vbus_fall, detach_ev, attach_known, attach_unknown;
  logic wr_ctrl, wr_int;

  // Software reset acts like hardware reset on the next cycle for all but the sense pipeline and read data
  assign soft_rst = CE_I && WR_I && (ADDR_I == ads_pkg::REG_CTRL) && WDATA_I[ads_pkg::CTRL_RESET_BIT]; // RQ17
  assign rst_all = RST_I || soft_rst; // RQ17

  // Three-stage synchronisers, reset to an empty connector's levels
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s_open_r <= 3'h7;
      s_ngnd_r <= 3'h7;
      s_hv_r <= 3'h0;
      s_vbus_r <= 3'h0;
    end else if (CE_I) begin
      s_open_r <= {s_open_r[1:0], ID_OPEN_COMPARATOR_I};
      s_ngnd_r <= {s_ngnd_r[1:0], ID_NOT_GROUNDED_COMPARATOR_I};
      s_hv_r <= {s_hv_r[1:0], ID_HIGH_VOLTAGE_COMPARATOR_I};
      s_vbus_r <= {s_vbus_r[1:0], VBUS_PRESENT_SENSE_I};
    end
  end

  // Filtered levels change only when the last two stages agree
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      open_q <= 1'b1;
      ngnd_q <= 1'b1;
      hv_q <= 1'b0;
      vbus_q <= 1'b0;
      adc_r <= 5'h00;
    end else if (CE_I) begin
      if (s_open_r[1] == s_open_r[2]) open_q <= s_open_r[2];
      if (s_ngnd_r[1] == s_ngnd_r[2]) ngnd_q <= s_ngnd_r[2];
      if (s_hv_r[1] == s_hv_r[2]) hv_q <= s_hv_r[2];
      if (s_vbus_r[1] == s_vbus_r[2]) vbus_q <= s_vbus_r[2];
      // ADC result is assumed stable while comparators settle
      adc_r <= ID_ADC_CODE_I;
    end
  end

  // Edge history starts idle, so reset makes no false edge
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      open_prev_r <= 1'b1;
      vbus_prev_r <= 1'b0;
    end else if (CE_I) begin
      open_prev_r <= open_q;
      vbus_prev_r <= vbus_q;
    end
  end

  // Detach edges
  assign open_rise = open_q && !open_prev_r;
  assign vbus_fall = !vbus_q && vbus_prev_r;

  // Sense levels to the classifier
  assign id_bus.adc_code = adc_r;
  assign id_bus.id_open = open_q;
  assign id_bus.id_not_gnd = ngnd_q;
  assign id_bus.id_high_v = hv_q;
  assign id_bus.vbus_present = vbus_q;

  ads_classify u_cls (
    .id(id_bus)
  );

  // Detach source depends on the accessory class
  always_comb begin
    case (acc_r)
      ads_pkg::ACC_UART, ads_pkg::ACC_UART_JIG: detach_ev = open_rise; // RQ6
      ads_pkg::ACC_TTY, ads_pkg::ACC_AUDIO1: detach_ev = open_rise; // RQ4
      ads_pkg::ACC_USB_HOST: detach_ev = vbus_fall; // RQ10
      ads_pkg::ACC_USB_CHG, ads_pkg::ACC_DED_CHG, ads_pkg::ACC_5W, ads_pkg::ACC_AV: detach_ev = vbus_fall; // RQ12
      ads_pkg::ACC_UNKNOWN: detach_ev = vbus_fall || open_rise; // RQ16
      default: detach_ev = vbus_fall || open_rise;
    endcase
  end

  // Identification completes from the identify state
  assign attach_known = (state_r == ads_pkg::ST_IDENT) && (id_bus.acc != ads_pkg::ACC_NONE) &&
                        (id_bus.acc != ads_pkg::ACC_UNKNOWN);
  assign attach_unknown = (state_r == ads_pkg::ST_IDENT) && (id_bus.acc == ads_pkg::ACC_UNKNOWN); // RQ15

  // Detection state machine; identification only under automatic select
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      state_r <= ads_pkg::ST_STANDBY;
      acc_r <= ads_pkg::ACC_NONE;
    end else if (CE_I) begin
      case (state_r)
        ads_pkg::ST_STANDBY: begin
          if (ctrl_r[ads_pkg::CTRL_MANUAL_SEL_BIT] && (!open_q || vbus_q)) begin
            state_r <= ads_pkg::ST_IDENT; // RQ14
          end
        end
        ads_pkg::ST_IDENT: begin
          acc_r <= id_bus.acc;
          if (attach_known) state_r <= ads_pkg::ST_ACTIVE;
          else if (attach_unknown) state_r <= ads_pkg::ST_UNKNOWN;
          else state_r <= ads_pkg::ST_STANDBY;
        end
        ads_pkg::ST_ACTIVE, ads_pkg::ST_UNKNOWN: begin
          if (detach_ev) begin
            state_r <= ads_pkg::ST_STANDBY; // RQ6 RQ10 RQ12 RQ16
            acc_r <= ads_pkg::ACC_NONE;
          end
        end
        default: state_r <= ads_pkg::ST_STANDBY;
      endcase
    end
  end

  // Register port decode
  assign wr_ctrl = CE_I && WR_I && (ADDR_I == ads_pkg::REG_CTRL);
  assign wr_int = CE_I && WR_I && (ADDR_I == ads_pkg::REG_INTSTAT);

  // Control register; reset bit is never stored
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      ctrl_r <= ads_pkg::CTRL_RESET_VAL; // RQ17
    end else if (wr_ctrl) begin
      ctrl_r <= {WDATA_I[7:1], 1'b0};
    end
  end

  // Device type bits follow the identified accessory
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      devtype_r <= 10'h000;
    end else if (CE_I) begin
      if (state_r == ads_pkg::ST_IDENT) begin
        devtype_r <= 10'h000;
        case (id_bus.acc)
          ads_pkg::ACC_TTY: devtype_r[ads_pkg::DT_TTY_BIT] <= 1'b1; // RQ1
          ads_pkg::ACC_UART: devtype_r[ads_pkg::DT_UART_BIT] <= 1'b1;
          ads_pkg::ACC_USB_HOST: devtype_r[ads_pkg::DT_USB_BIT] <= 1'b1; // RQ7
          ads_pkg::ACC_USB_CHG: devtype_r[ads_pkg::DT_USB_CHG_BIT] <= 1'b1; // RQ11
          ads_pkg::ACC_DED_CHG: devtype_r[ads_pkg::DT_DED_CHG_BIT] <= 1'b1; // RQ11
          ads_pkg::ACC_5W: devtype_r[ads_pkg::DT_5W_BIT] <= 1'b1; // RQ13
          ads_pkg::ACC_AV: devtype_r[ads_pkg::DT_AV_BIT] <= 1'b1; // RQ13
          ads_pkg::ACC_AUDIO1: devtype_r[ads_pkg::DT_AUDIO1_BIT] <= 1'b1;
          ads_pkg::ACC_USB_JIG, ads_pkg::ACC_UART_JIG: devtype_r[ads_pkg::DT_JIG_BIT] <= 1'b1;
          ads_pkg::ACC_FACTORY: devtype_r[ads_pkg::DT_FACTORY_BIT] <= 1'b1;
          default: devtype_r <= 10'h000;
        endcase
      end else if (state_r == ads_pkg::ST_STANDBY) begin
        devtype_r <= 10'h000;
      end
    end
  end

  // Sticky flags, write one to clear; a new event wins
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      intstat_r <= 3'h0;
    end else if (CE_I) begin
      if (wr_int) intstat_r <= intstat_r & ~WDATA_I[2:0];
      if (attach_known) intstat_r[ads_pkg::INT_ATTACH_BIT] <= 1'b1; // RQ1
      if (attach_unknown) intstat_r[ads_pkg::INT_UNKNOWN_BIT] <= 1'b1; // RQ15
      if ((state_r == ads_pkg::ST_ACTIVE || state_r == ads_pkg::ST_UNKNOWN) && detach_ev) begin
        intstat_r[ads_pkg::INT_DETACH_BIT] <= 1'b1; // RQ6 RQ10 RQ12 RQ16
      end
    end
  end

  // Data switch gating by hold and wait, counted in cycles
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      wait_cnt_r <= 16'h0000;
      data_ok_r <= 1'b0;
    end else if (CE_I) begin
      if (state_r != ads_pkg::ST_ACTIVE) begin
        wait_cnt_r <= 16'h0000;
        data_ok_r <= 1'b0;
      end else if (ctrl_r[ads_pkg::CTRL_SWITCH_HOLD_OVERRIDE_BIT]) begin
        data_ok_r <= 1'b1; // RQ8
      end else if (ctrl_r[ads_pkg::CTRL_WAIT_BIT] && !data_ok_r) begin
        if (wait_cnt_r >= WAIT_COUNT) data_ok_r <= 1'b1; // RQ8 RQ23
        else wait_cnt_r <= wait_cnt_r + 16'h0001; // RQ23
      end
    end
  end

  // Switch selection; host and jig data wait for the gate, host relies on it
  always_comb begin
    sw_nxt = 7'h00;
    if (state_r == ads_pkg::ST_ACTIVE) begin
      case (acc_r)
        ads_pkg::ACC_TTY: begin
          sw_nxt[ads_pkg::SW_SPKR_DP] = 1'b1; // RQ2
          sw_nxt[ads_pkg::SW_MIC_VBUS] = 1'b1; // RQ2
          sw_nxt[ads_pkg::SW_SPKL_DM] = ctrl_r[ads_pkg::CTRL_TTY_SPKL_BIT]; // RQ2
          sw_nxt[ads_pkg::SW_OTG_VBUS] = 1'b0; // RQ3
          sw_nxt[ads_pkg::SW_VBUS_PATH] = 1'b0; // RQ3
        end
        ads_pkg::ACC_AUDIO1: begin
          sw_nxt[ads_pkg::SW_SPKR_DP] = 1'b1;
          sw_nxt[ads_pkg::SW_SPKL_DM] = 1'b1;
          sw_nxt[ads_pkg::SW_MIC_VBUS] = 1'b1;
        end
        ads_pkg::ACC_UART: sw_nxt[ads_pkg::SW_RXD_TXD] = 1'b1; // RQ5
        ads_pkg::ACC_UART_JIG: sw_nxt[ads_pkg::SW_RXD_TXD] = data_ok_r;
        ads_pkg::ACC_USB_HOST: sw_nxt[ads_pkg::SW_DP_DM] = data_ok_r; // RQ7 RQ8
        ads_pkg::ACC_USB_JIG: sw_nxt[ads_pkg::SW_DP_DM] = data_ok_r;
        ads_pkg::ACC_USB_CHG: sw_nxt[ads_pkg::SW_DP_DM] = 1'b1; // RQ11
        default: sw_nxt = 7'h00;
      endcase
    end
  end

  // Switch outputs registered; standby forces everything open
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      sw_r <= 7'h00;
    end else if (CE_I) begin
      sw_r <= (state_r == ads_pkg::ST_STANDBY) ? 7'h00 : sw_nxt; // RQ22
    end
  end

  // Key detection only for audio type 1, never for TTY
  always_ff @(posedge CLK_SYS_I) begin
    if (rst_all) begin
      KEY_DETECT_EN_O <= 1'b0;
    end else if (CE_I) begin
      KEY_DETECT_EN_O <= (state_r == ads_pkg::ST_ACTIVE) && (acc_r == ads_pkg::ACC_AUDIO1); // RQ4
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
    end else if (CE_I) begin
      RDATA_O <= 16'h0000;
      if (RD_I) begin
        case (ADDR_I)
          ads_pkg::REG_CTRL: RDATA_O <= {8'h00, ctrl_r};
          ads_pkg::REG_DEVTYPE: RDATA_O <= {6'h00, devtype_r};
          ads_pkg::REG_INTSTAT: RDATA_O <= {13'h0000, intstat_r};
          ads_pkg::REG_SWITCH: RDATA_O <= {9'h000, sw_r};
          ads_pkg::REG_IDSTAT: RDATA_O <= {6'h00, state_r, vbus_q, hv_q, ngnd_q, open_q, adc_r[3:0]};
          default: RDATA_O <= 16'h0000;
        endcase
      end
    end
  end

  // Switch vector to pins
  assign SW_HOST_DATA_O = sw_r[ads_pkg::SW_DP_DM];
  assign SW_UART_O = sw_r[ads_pkg::SW_RXD_TXD];
  assign SW_RIGHT_AUDIO_O = sw_r[ads_pkg::SW_SPKR_DP];
  assign SW_LEFT_AUDIO_O = sw_r[ads_pkg::SW_SPKL_DM];
  assign SW_MIC_VBUS_O = sw_r[ads_pkg::SW_MIC_VBUS];
  assign OTG_VBUS_SWITCH_O = sw_r[ads_pkg::SW_OTG_VBUS];
  assign VBUS_PATH_SWITCH_O = sw_r[ads_pkg::SW_VBUS_PATH];

endmodule
`default_nettype wire

// *** ads_top_assertions.sv ***
// Port checker for the accessory detect and switch control block
`timescale 1ns/1ps
`default_nettype none
module ads_top_chk (
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic [15:0] RDATA_O,
  // Sense inputs
  input wire logic ID_OPEN_COMPARATOR_I,
  input wire logic VBUS_PRESENT_SENSE_I,
  // Switch controls
  input wire logic SW_HOST_DATA_O,
  input wire logic SW_UART_O,
  input wire logic SW_RIGHT_AUDIO_O,
  input wire logic SW_LEFT_AUDIO_O,
  input wire logic SW_MIC_VBUS_O,
  input wire logic OTG_VBUS_SWITCH_O,
  input wire logic VBUS_PATH_SWITCH_O,
  input wire logic KEY_DETECT_EN_O
);
  logic gate_r;
  logic [4:0] idle_r;
  logic any_sw;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Any routing switch closed
  assign any_sw = SW_HOST_DATA_O | SW_UART_O | SW_RIGHT_AUDIO_O | SW_LEFT_AUDIO_O | SW_MIC_VBUS_O
    | OTG_VBUS_SWITCH_O | VBUS_PATH_SWITCH_O;
  // Mirror of hold or wait; reset value has both low
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      gate_r <= 1'b0;
    end else if (CE_I && WR_I && ADDR_I == ads_pkg::REG_CTRL) begin
      gate_r <= (WDATA_I[ads_pkg::CTRL_SWITCH_HOLD_OVERRIDE_BIT] | WDATA_I[ads_pkg::CTRL_WAIT_BIT]) & !WDATA_I[ads_pkg::CTRL_RESET_BIT];
    end
  end
  // Cycles with no accessory on the connector, saturating
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || !ID_OPEN_COMPARATOR_I || VBUS_PRESENT_SENSE_I) begin
      idle_r <= 5'h00;
    end else if (idle_r != 5'h1F) begin
      idle_r <= idle_r + 5'h01;
    end
  end
  reset_clear_a: assert property ($fell(RST_I) |-> !any_sw && RDATA_O == 16'h0000 && !KEY_DETECT_EN_O)
    else $error("outputs set after reset");
  tty_isolate_a: assert property (SW_RIGHT_AUDIO_O |-> !OTG_VBUS_SWITCH_O && !VBUS_PATH_SWITCH_O)
    else $error("vbus path closed with audio");
  left_audio_a: assert property (SW_LEFT_AUDIO_O |-> SW_RIGHT_AUDIO_O && SW_MIC_VBUS_O)
    else $error("left audio closed alone");
  tty_no_key_a: assert property (SW_RIGHT_AUDIO_O && !SW_LEFT_AUDIO_O |-> !KEY_DETECT_EN_O)
    else $error("key detect on for converter");
  uart_path_a: assert property (SW_UART_O |-> !SW_HOST_DATA_O && !SW_RIGHT_AUDIO_O)
    else $error("uart shares data lines");
  vbus_detach_a: assert property ($fell(VBUS_PRESENT_SENSE_I) && SW_HOST_DATA_O |-> ##[1:12] !SW_HOST_DATA_O)
    else $error("host data closed after vbus loss");
  float_detach_a: assert property ($rose(ID_OPEN_COMPARATOR_I) && (SW_UART_O || SW_RIGHT_AUDIO_O)
    |-> ##[1:12] !(SW_UART_O || SW_RIGHT_AUDIO_O))
    else $error("switch closed after id_line_floating");
  standby_open_a: assert property (idle_r >= 5'h0C |-> !any_sw)
    else $error("switch closed in standby");
  wait_gate_a: assert property ($rose(SW_HOST_DATA_O) |-> gate_r)
    else $error("host data closed ungated");
  // Main scenarios
  tty_left_c: cover property (SW_LEFT_AUDIO_O && !KEY_DETECT_EN_O);
  uart_c: cover property (SW_UART_O);
  host_c: cover property (SW_HOST_DATA_O);
  key_c: cover property (KEY_DETECT_EN_O);
endmodule
bind ads_top ads_top_chk chk_u (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RDATA_O(RDATA_O), .ID_OPEN_COMPARATOR_I(ID_OPEN_COMPARATOR_I),
  .VBUS_PRESENT_SENSE_I(VBUS_PRESENT_SENSE_I), .SW_HOST_DATA_O(SW_HOST_DATA_O), .SW_UART_O(SW_UART_O),
  .SW_RIGHT_AUDIO_O(SW_RIGHT_AUDIO_O), .SW_LEFT_AUDIO_O(SW_LEFT_AUDIO_O), .SW_MIC_VBUS_O(SW_MIC_VBUS_O),
  .OTG_VBUS_SWITCH_O(OTG_VBUS_SWITCH_O), .VBUS_PATH_SWITCH_O(VBUS_PATH_SWITCH_O), .KEY_DETECT_EN_O(KEY_DETECT_EN_O));
`default_nettype wire

// *** ads_acc_model.sv ***
// Accessory model driving the connector comparators, ADC code and VBUS sense
`timescale 1ns/1ps
`default_nettype none
module ads_acc_model (
  // Clock
  input wire logic clk_i,
  // Accessory choice
  input wire logic plugged_i,
  input wire logic vbus_i,
  input wire logic [4:0] code_i,
  // Connector sense levels
  output logic id_open_o,
  output logic id_not_gnd_o,
  output logic id_high_v_o,
  output logic vbus_o,
  output logic [4:0] adc_o
);
  // Comparator pattern follows the pin load; an empty connector reads floating
  always_ff @(posedge clk_i) begin
    if (!plugged_i || code_i == 5'h1F) begin
      {id_open_o, id_not_gnd_o, id_high_v_o} <= 3'b110;
    end else if (code_i == 5'h12) begin
      {id_open_o, id_not_gnd_o, id_high_v_o} <= 3'b111;
    end else if (code_i == 5'h00) begin
      {id_open_o, id_not_gnd_o, id_high_v_o} <= 3'b000;
    end else begin
      {id_open_o, id_not_gnd_o, id_high_v_o} <= 3'b010;
    end
  end
  // Code and VBUS follow the plug at one edge
  always_ff @(posedge clk_i) begin
    adc_o <= plugged_i ? code_i : 5'h1F;
    vbus_o <= plugged_i & vbus_i;
  end
endmodule
`default_nettype wire

// *** tb_accessory_detect_switch_ctrl.sv ***
// Self-checking testbench for the accessory detect and switch control block
`timescale 1ns/1ps
`default_nettype none
module tb_accessory_detect_switch_ctrl;
  localparam logic [15:0] WAIT_N = 16'h0004;
  localparam logic [3:0] CTL = ads_pkg::REG_CTRL, IST = ads_pkg::REG_INTSTAT;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, plug = 1'b0, vbus = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [15:0] lfsr = 16'h005F;
  logic [4:0] code = 5'h1F, adc;
  logic id_open, id_ngnd, id_hv, vbus_s, key;
  logic [6:0] sw;
  logic [15:0] exp_q[$];
  int err_count = 0, cmp_count = 0, t1, t2;
  logic [4:0] unk[7] = '{5'h00, 5'h15, 5'h18, 5'h19, 5'h1C, 5'h13, 5'h14};
  logic [3:0] ro[3] = '{4'h1, 4'h3, 4'hF};
  always #2 clk = ~clk;
  ads_top #(.WAIT_COUNT(WAIT_N)) dut_u (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(1'b1), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ID_OPEN_COMPARATOR_I(id_open), .ID_NOT_GROUNDED_COMPARATOR_I(id_ngnd),
    .ID_HIGH_VOLTAGE_COMPARATOR_I(id_hv), .VBUS_PRESENT_SENSE_I(vbus_s), .ID_ADC_CODE_I(adc),
    .SW_HOST_DATA_O(sw[0]), .SW_UART_O(sw[1]), .SW_RIGHT_AUDIO_O(sw[2]), .SW_LEFT_AUDIO_O(sw[3]),
    .SW_MIC_VBUS_O(sw[4]), .OTG_VBUS_SWITCH_O(sw[5]), .VBUS_PATH_SWITCH_O(sw[6]), .KEY_DETECT_EN_O(key));
  ads_acc_model acc_u (.clk_i(clk), .plugged_i(plug), .vbus_i(vbus), .code_i(code), .id_open_o(id_open),
    .id_not_gnd_o(id_ngnd), .id_high_v_o(id_hv), .vbus_o(vbus_s), .adc_o(adc));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cmpv(input logic [15:0] e, input logic [15:0] a);
    cmp_count++;
    if (a !== e) begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, e, a);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Oldest note against the read data
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      if (exp_q.size() == 0) cmpv(16'hFFFF, rdata);
      else cmpv(exp_q.pop_front(), rdata);
    end
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // Sample once the edge has settled
  task automatic chk_sw(input logic [6:0] e, input logic k);
    #1;
    cmpv({8'h00, k, e}, {8'h00, key, sw});
  endtask
  task automatic attach(input logic [4:0] c, input logic v);
    wr_reg(IST, 16'h0007);
    @(posedge clk);
    code <= c;
    vbus <= v;
    plug <= 1'b1;
  endtask
  // VBUS drops as the pin floats, so no re-identification
  task automatic unplug();
    wr_reg(IST, 16'h0007);
    @(posedge clk);
    plug <= 1'b0;
    vbus <= 1'b0;
    cyc(16);
    rd_reg(IST, 16'h0002);
    chk_sw(7'h00, 1'b0);
  endtask
  task automatic one(input logic [4:0] c, input logic v, input logic [15:0] dt, input logic [15:0] it,
      input logic [6:0] s, input logic k);
    attach(c, v);
    cyc(16);
    rd_reg(ads_pkg::REG_DEVTYPE, dt);
    rd_reg(IST, it);
    chk_sw(s, k);
    unplug();
    $display("done: accessory %h", c);
  endtask
  // Cycles from plug-in to host switch close
  task automatic t_close(output int n);
    attach(5'h1F, 1'b1);
    n = 0;
    while (sw[0] !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 60) cmpv(16'h0001, 16'h0000);
    unplug();
  endtask
  initial begin
    cyc(10);
    rst <= 1'b0;
    rd_reg(CTL, {8'h00, ads_pkg::CTRL_RESET_VAL});
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wr_reg(ro[i], lfsr);
      rd_reg(ro[i], 16'h0000);
    end
    chk_sw(7'h00, 1'b0);
    $display("done: reset");
    wr_reg(CTL, 16'h0012);
    one(5'h1D, 1'b0, 16'h0040, 16'h0001, 7'h1C, 1'b0);
    wr_reg(CTL, 16'h0002);
    one(5'h1D, 1'b0, 16'h0040, 16'h0001, 7'h14, 1'b0);
    one(5'h1E, 1'b0, 16'h0080, 16'h0001, 7'h1C, 1'b1);
    one(5'h16, 1'b0, 16'h0002, 16'h0001, 7'h02, 1'b0);
    one(5'h17, 1'b1, 16'h0010, 16'h0001, 7'h00, 1'b0);
    one(5'h1B, 1'b1, 16'h0010, 16'h0001, 7'h00, 1'b0);
    one(5'h1A, 1'b1, 16'h0020, 16'h0001, 7'h00, 1'b0);
    one(5'h12, 1'b1, 16'h0200, 16'h0001, 7'h00, 1'b0);
    for (int c = 14; c < 18; c++) one(5'(c), 1'b0, 16'h0100, 16'h0001, 7'h00, 1'b0);
    for (int i = 0; i < 7; i++) one(unk[i], 1'(i % 2), 16'h0000, 16'h0004, 7'h00, 1'b0);
    one(5'h1F, 1'b1, 16'h0001, 16'h0001, 7'h00, 1'b0);
    attach(5'h1F, 1'b1);
    cyc(20);
    chk_sw(7'h00, 1'b0);
    wr_reg(CTL, 16'h000A);
    cyc(WAIT_N + 10);
    chk_sw(7'h01, 1'b0);
    unplug();
    wr_reg(CTL, 16'h0006);
    t_close(t1);
    wr_reg(CTL, 16'h000A);
    t_close(t2);
    cmpv(16'h0001, {15'h0000, t2 - t1 >= WAIT_N - 1 && t2 - t1 <= WAIT_N + 1});
    $display("done: gating");
    wr_reg(CTL, 16'h001E);
    wr_reg(CTL, 16'h0001);
    cyc(2);
    rd_reg(CTL, {8'h00, ads_pkg::CTRL_RESET_VAL});
    rd_reg(IST, 16'h0000);
    cyc(4);
    cmpv(16'h0000, 16'(exp_q.size()));
    $display("done: soft reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
